/* pkg/nfc_pkg.sv */
// Constants and carrier types for the NAND host sequencer.
// Assumes a 100 MHz system clock; times are converted to cycles here.
package nfc_pkg;
  localparam int CLK_NS = 10;
  // Device timing in printed units
  localparam int LATCH_LOW_TO_STROBE_ID_NS   = 100;
  localparam int SELECT_LOW_TO_STROBE_ID_NS  = 100;
  localparam int LATCH_LOW_TO_STROBE_READ_NS = 50;
  localparam int READY_TO_FIRST_STROBE_NS    = 20;
  localparam int SELECT_HIGH_TERMINATE_NS    = 100;
  localparam int WRITE_PULSE_NS              = 25;
  localparam int WRITE_HIGH_NS               = 25;
  localparam int READ_PULSE_NS               = 35;
  localparam int READ_HIGH_NS                = 15;
  localparam int WRITE_TO_BUSY_NS            = 200;
  localparam int ARRAY_FETCH_TIME_US         = 25;
  localparam int PROGRAM_TIME_US             = 1000;
  localparam int ERASE_TIME_US               = 10000;
  localparam int RESET_ERASE_US              = 500;
  // Least times round up to whole cycles
  localparam int T_ID_LATCH  = (LATCH_LOW_TO_STROBE_ID_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ID_SELECT = (SELECT_LOW_TO_STROBE_ID_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RD_LATCH  = (LATCH_LOW_TO_STROBE_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RDY_STRB  = (READY_TO_FIRST_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CE_TERM   = (SELECT_HIGH_TERMINATE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WP        = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WH        = (WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RP        = (READ_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_REH       = (READ_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WB        = (WRITE_TO_BUSY_NS + CLK_NS - 1) / CLK_NS;
  // Worst busy period across fetch, program, erase and reset
  localparam int WORST_BUSY_US = ERASE_TIME_US;
  localparam int T_TIMEOUT   = WORST_BUSY_US * (1000 / CLK_NS);
  localparam int MAX_PROGRAMS = 5;
  localparam int CNT_W = 24;
  // Command opcodes issued by the host
  localparam logic [7:0] CMD_READ0  = 8'h00;
  localparam logic [7:0] CMD_PROG_D = 8'h80;
  localparam logic [7:0] CMD_PROG   = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_ID     = 8'h90;
  localparam logic [7:0] CMD_RESET  = 8'hFF;

  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_PROG  = 3'h1,
    OP_ERASE = 3'h2,
    OP_ID    = 3'h3,
    OP_RESET = 3'h4
  } nfc_op_e;

  typedef struct packed {
    nfc_op_e     op;
    logic [23:0] addr;
    logic [9:0]  count;
  } nfc_req_s;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       output_strobe_n;
    logic [7:0] dout;
    logic       doe;
  } nfc_pins_s;
endpackage : nfc_pkg

/* rtl/nfc_fifo.sv */
// Parameterised synchronous FIFO for read data toward the user.
// Assumes one clock; clock enable freezes all state.
`timescale 1ns/1ps
module nfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("Depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;
  // Honest full and empty from pointer difference
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  // Storage array, written without reset
  always_ff @(posedge sys_clk)
  begin
    if (clk_en && push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end
  // Pointer registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (clk_en)
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : nfc_fifo

/* rtl/nfc_host.sv */
// Host sequencer driving a byte-wide NAND flash over its strobe pins.
// Assumes ready_busy_n and data-in pins come asynchronously from the device.
`timescale 1ns/1ps
// Behaviour
// - Host programs one page at most 5 times before block erase; the count covers only the last page programmed and clears on any erase.
// - Select held high 100 ns after last byte ends sequential read.
// - ID read: 100 ns from latch low to first read strobe.
// - ID read: 100 ns from select low to first read strobe.
// - Normal read: 50 ns from latch low to read strobe.
// - Wait 20 ns after ready before first read strobe fall.
module nfc_host #(
  parameter int TIMEOUT_CYCLES = nfc_pkg::T_TIMEOUT,
  parameter int FIFO_DEPTH     = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              clk_en,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire nfc_pkg::nfc_req_s req,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [7:0]        wr_data,
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic      [7:0]        rd_data,
  output logic                   done,
  output logic                   timeout_err,
  output logic                   prog_limit_err,
  input  wire logic              ready_busy_n,
  input  wire logic [7:0]        io_in,
  output logic      [7:0]        io_out,
  output logic                   io_oe,
  output logic                   ce_n,
  output logic                   cle,
  output logic                   ale,
  output logic                   we_n,
  output logic                   output_strobe_n
);
  initial
  begin
    if (TIMEOUT_CYCLES < 1
        || TIMEOUT_CYCLES + nfc_pkg::T_WB >= (1 << nfc_pkg::CNT_W))
      $error("Timeout does not fit the counter");
  end

  typedef enum logic [3:0] {
    S_IDLE  = 4'h0, S_WRDY  = 4'h1, S_BYTE  = 4'h2, S_WLOW  = 4'h3,
    S_WHIGH = 4'h4, S_BUSY  = 4'h5, S_GAP   = 4'h6, S_RLOW  = 4'h7,
    S_RHIGH = 4'h8, S_DONE  = 4'h9, S_CEOFF = 4'hA
  } nfc_state_e;

  typedef struct packed {
    nfc_state_e        st;
    nfc_pkg::nfc_req_s r;
    nfc_pkg::nfc_pins_s p;
    logic [2:0]        seq;       // Byte index in command sequence
    logic [nfc_pkg::CNT_W-1:0] cnt;
    logic [9:0]        left;
    logic [2:0]        prog_cnt;
    logic [13:0]       prog_page;
    logic [1:0]        rb_sync;
    logic [7:0]        din;
    logic [7:0]        din_s;
    logic              push;
    logic              done;
    logic              tmo;
    logic              plim;
  } nfc_host_s;

  nfc_host_s q;
  nfc_host_s next_q;
  logic      rb_ready;
  logic      fifo_in_ready;

  // Byte for step i of a command sequence; returns command flag in bit 8
  function automatic logic [8:0] seq_byte(input nfc_pkg::nfc_req_s r,
                                          input logic [2:0] i);
    logic [8:0] b;
    b = {1'b0, 8'h00};
    unique case (r.op)
      nfc_pkg::OP_READ:
        b = (i == 3'h0) ? {1'b1, nfc_pkg::CMD_READ0} : {1'b0, r.addr[8*i-8 +: 8]};
      nfc_pkg::OP_PROG:
        b = (i == 3'h0) ? {1'b1, nfc_pkg::CMD_PROG_D} : {1'b0, r.addr[8*i-8 +: 8]};
      nfc_pkg::OP_ERASE:
        b = (i == 3'h0) ? {1'b1, nfc_pkg::CMD_ERASE1} :
            (i == 3'h3) ? {1'b1, nfc_pkg::CMD_ERASE2} :
                          {1'b0, r.addr[8*i +: 8]};
      nfc_pkg::OP_ID:
        b = (i == 3'h0) ? {1'b1, nfc_pkg::CMD_ID} : {1'b0, 8'h00};
      default:
        b = {1'b1, nfc_pkg::CMD_RESET};
    endcase
    return b;
  endfunction : seq_byte

  // Number of command and address bytes for an operation
  function automatic logic [2:0] seq_len(input nfc_pkg::nfc_op_e op);
    logic [2:0] n;
    n = 3'h1;
    unique case (op)
      nfc_pkg::OP_READ, nfc_pkg::OP_PROG: n = 3'h4;
      nfc_pkg::OP_ERASE: n = 3'h4;
      nfc_pkg::OP_ID:    n = 3'h2;
      default:           n = 3'h1;
    endcase
    return n;
  endfunction : seq_len

  assign rb_ready = q.rb_sync[1];
  assign req_ready = (q.st == S_IDLE);
  assign wr_ready  = (q.st == S_GAP) && (q.r.op == nfc_pkg::OP_PROG)
                     && (q.left != 10'h000) && q.p.we_n
                     && (q.cnt == '0);

  // Next-state logic for the whole sequencer
  always_comb
  begin
    logic [8:0] b;
    next_q = q;
    b = seq_byte(q.r, q.seq);
    next_q.rb_sync = {q.rb_sync[0], ready_busy_n};
    next_q.din_s   = io_in;
    next_q.din     = q.din_s;
    next_q.push    = 1'b0;
    next_q.done    = 1'b0;
    if (q.cnt != '0)
      next_q.cnt = q.cnt - 1'b1;
    unique case (q.st)
      S_IDLE:
        if (req_valid)
        begin
          next_q.r = req;
          next_q.seq = 3'h0;
          next_q.left = req.count;
          next_q.tmo = 1'b0;
          next_q.plim = 1'b0;
          next_q.p.ce_n = 1'b0;
          // Track repeated programs of one page, cleared by block erase
          if (req.op == nfc_pkg::OP_ERASE)
            next_q.prog_cnt = 3'h0;
          if (req.op == nfc_pkg::OP_PROG)
          begin
            if (req.addr[21:8] != q.prog_page)
              next_q.prog_cnt = 3'h0;
            else if (q.prog_cnt >= 3'(nfc_pkg::MAX_PROGRAMS))
            begin
              next_q.plim = 1'b1;
              next_q.p.ce_n = 1'b1;
              next_q.done = 1'b1;
            end
          end
          if (!next_q.plim)
          begin
            next_q.st = (req.op == nfc_pkg::OP_RESET) ? S_BYTE : S_WRDY;
            next_q.cnt = nfc_pkg::CNT_W'(TIMEOUT_CYCLES);
          end
        end
      S_WRDY:
        // Only reset may be issued while busy
        if (rb_ready)
        begin
          next_q.st = S_BYTE;
          next_q.cnt = '0;
        end
        else if (q.cnt == '0)
        begin
          next_q.tmo = 1'b1;
          next_q.st = S_CEOFF;
          next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_CE_TERM);
        end
      S_BYTE:
      begin
        next_q.p.cle = b[8];
        next_q.p.ale = !b[8];
        next_q.p.dout = b[7:0];
        next_q.p.doe = 1'b1;
        next_q.p.we_n = 1'b0;
        next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_WP);
        next_q.st = S_WLOW;
      end
      S_WLOW:
        if (q.cnt == '0)
        begin
          next_q.p.we_n = 1'b1;
          next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_WH);
          next_q.st = S_WHIGH;
        end
      S_WHIGH:
        if (q.cnt == '0)
        begin
          next_q.p.cle = 1'b0;
          next_q.p.ale = 1'b0;
          next_q.p.doe = 1'b0;
          next_q.seq = q.seq + 1'b1;
          if (q.seq + 1'b1 < seq_len(q.r.op))
            next_q.st = S_BYTE;
          else if (q.r.op == nfc_pkg::OP_ID)
          begin
            // ID needs both latch-low and select-low gaps
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_ID_LATCH);
            next_q.st = S_GAP;
          end
          else if (q.r.op == nfc_pkg::OP_PROG && q.seq == 3'h3)
          begin
            next_q.cnt = '0;
            next_q.st = S_GAP;
          end
          else
          begin
            // Ready is masked while busy may still be on its way
            next_q.cnt = nfc_pkg::CNT_W'(TIMEOUT_CYCLES + nfc_pkg::T_WB);
            next_q.st = S_BUSY;
          end
        end
      S_BUSY:
        // Busy covers fetch, program, erase and reset recovery
        if (q.cnt >= nfc_pkg::CNT_W'(TIMEOUT_CYCLES))
          next_q.st = S_BUSY;
        else if (rb_ready)
        begin
          if (q.r.op == nfc_pkg::OP_READ && q.left != 10'h000)
          begin
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_RDY_STRB);
            next_q.st = S_GAP;
          end
          else
          begin
            if (q.r.op == nfc_pkg::OP_PROG)
            begin
              next_q.prog_page = q.r.addr[21:8];
              next_q.prog_cnt = q.prog_cnt + 1'b1;
            end
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_CE_TERM);
            next_q.st = S_CEOFF;
          end
        end
        else if (q.cnt == '0)
        begin
          next_q.tmo = 1'b1;
          next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_CE_TERM);
          next_q.st = S_CEOFF;
        end
      S_GAP:
        if (q.r.op == nfc_pkg::OP_PROG)
        begin
          // Data pulse ends before the next byte or the confirm command
          if (!q.p.we_n)
          begin
            if (q.cnt == '0)
            begin
              next_q.p.we_n = 1'b1;
              next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_WH);
            end
          end
          else if (q.cnt == '0 && q.left == 10'h000)
          begin
            next_q.p.cle = 1'b1;
            next_q.p.dout = nfc_pkg::CMD_PROG;
            next_q.p.doe = 1'b1;
            next_q.p.we_n = 1'b0;
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_WP);
            next_q.seq = 3'h4;
            next_q.st = S_WLOW;
          end
          else if (wr_valid && wr_ready)
          begin
            next_q.p.dout = wr_data;
            next_q.p.doe = 1'b1;
            next_q.p.we_n = 1'b0;
            next_q.left = q.left - 1'b1;
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_WP);
          end
        end
        else if (q.cnt == '0 && fifo_in_ready)
        begin
          next_q.p.output_strobe_n = 1'b0;
          next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_RP);
          next_q.st = S_RLOW;
        end
      S_RLOW:
        if (q.cnt == '0)
        begin
          // Sample data two cycles after access, past the synchroniser
          next_q.p.output_strobe_n = 1'b1;
          next_q.push = 1'b1;
          next_q.left = q.left - 1'b1;
          next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_REH);
          next_q.st = S_RHIGH;
        end
      S_RHIGH:
        if (q.cnt == '0)
        begin
          if (q.left != 10'h000)
            next_q.st = S_GAP;
          else
          begin
            // Enter S_CEOFF, which raises select one cycle later, to end the sequential read
            next_q.cnt = nfc_pkg::CNT_W'(nfc_pkg::T_CE_TERM);
            next_q.st = S_CEOFF;
          end
        end
      S_CEOFF:
      begin
        next_q.p.ce_n = 1'b1;
        if (q.cnt == '0)
        begin
          next_q.done = 1'b1;
          next_q.st = S_IDLE;
        end
      end
      default:
        next_q.st = S_IDLE;
    endcase
  end

  // Single state register, frozen by clock enable
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.p.ce_n <= 1'b1;
      q.p.we_n <= 1'b1;
      q.p.output_strobe_n <= 1'b1;
    end
    else if (clk_en)
      q <= next_q;
  end

  nfc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (q.din),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  assign io_out          = q.p.dout;
  assign io_oe           = q.p.doe;
  assign ce_n            = q.p.ce_n;
  assign cle             = q.p.cle;
  assign ale             = q.p.ale;
  assign we_n            = q.p.we_n;
  assign output_strobe_n = q.p.output_strobe_n;
  assign done            = q.done;
  assign timeout_err     = q.tmo;
  assign prog_limit_err  = q.plim;

  // All checks run on the system clock, off during reset
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // Read strobe never falls while busy is seen
  a_strobe_after_ready: assert property (
    $fell(output_strobe_n) |-> $past(rb_ready))
    else $error("Read strobe fell while busy");
  // Address latch low two and three cycles before read strobe falls
  a_latch_to_strobe: assert property (
    $fell(output_strobe_n) |-> !$past(ale, 2) && !$past(ale, 3))
    else $error("Read strobe too soon after address latch");
  // Strobes never overlap
  a_strobe_exclusive: assert property (
    !(!we_n && !output_strobe_n))
    else $error("Write and read strobes both low");
  // Command latched only while bus is driven
  a_cmd_driven: assert property (
    (cle && !we_n) |-> io_oe)
    else $error("Command strobe without driven bus");
  // Select is high once three enabled cycles follow the last byte
  sequence s_last_byte;
    $rose(output_strobe_n) && q.left == 10'h000 && q.st == S_RHIGH
      && clk_en;
  endsequence
  sequence s_run_three;
    clk_en[*3];
  endsequence
  a_select_term: assert property (
    s_last_byte ##1 s_run_three |=> ce_n)
    else $error("Select not raised after last byte");
  // Timeout flag only from busy waits
  a_timeout_src: assert property (
    $rose(timeout_err) |-> $past(q.st == S_BUSY || q.st == S_WRDY))
    else $error("Timeout flagged outside a wait");
  // Program limit refuses the request at once
  a_prog_limit: assert property (
    $rose(prog_limit_err) |-> done && ce_n)
    else $error("Program limit did not refuse request");
  // Commands other than reset wait for ready
  a_cmd_ready: assert property (
    (q.st == S_BYTE && q.seq == 3'h0 && q.r.op != nfc_pkg::OP_RESET)
      |-> $past(rb_ready))
    else $error("Command issued while busy");
endmodule : nfc_host

/* sim/nfc_dev_model.sv */
// Behavioural NAND device model facing the host sequencer's pins.
// Assumes a pull-up on ready_busy_n; all delays are in ns.
`timescale 1ns/1ps
module nfc_dev_model #(
  parameter int         FETCH_NS = 3000,
  parameter int         PROG_NS  = 5000,
  parameter int         ERASE_NS = 8000,
  parameter int         RST_NS   = 600,
  parameter logic [7:0] ID0      = 8'h5A, // Arbitrary identity value
  parameter logic [7:0] ID1      = 8'hC3  // Arbitrary identity value
) (
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       output_strobe_n,
  input  wire logic [7:0] io,
  input  wire logic       slow,
  input  wire logic       hang,
  output logic            ready_busy_n,
  output logic      [7:0] dq,
  output logic            dq_oe,
  output int              viol,
  output int              nprog
);
  logic [7:0]  mem [int];
  int          pcnt [int];
  logic [7:0]  pbuf [$];
  logic [7:0]  cmd;
  logic [23:0] a;
  int          na, col, page, k;
  logic        busy, rd_busy;
  time         t_end, t_ale, t_ce, t_rdy;

  // Open drain: released level is the pull-up
  assign ready_busy_n = !busy;

  initial
  begin
    {viol, nprog, na, col, page, k} = '0;
    {busy, rd_busy, dq_oe, dq, cmd, a} = '0;
    {t_end, t_ale, t_ce, t_rdy} = '0;
  end

  // Busy starts within 200 ns; slow mode triples the length
  task automatic start(input int ns, input logic rd);
    busy <= #100 1'b1;
    rd_busy = rd;
    t_end = $time + 100 + (slow ? 3 : 1) * ns;
  endtask : start

  // Operation end; hang keeps busy for as long as it is set
  always #10 if (busy && !hang && $time >= t_end)
  begin
    busy = 1'b0;
    t_rdy = $time;
  end

  always @(negedge ale) t_ale = $time;
  always @(negedge ce_n) t_ce = $time;

  // Select rise: data released; read busy cut short, others ignore it
  always @(posedge ce_n)
  begin
    dq_oe = 1'b0;
    if (busy && rd_busy) t_end = $time + 100;
  end

  // Command, address and data capture on write strobe rise
  always @(posedge we_n) if (!ce_n)
  begin
    if (cle)
    begin
      if (busy && io != 8'hFF) viol++;
      cmd = io;
      na = 0;
      case (io)
        8'hFF: start(RST_NS, 1'b0);
        8'h80: pbuf.delete();
        8'h10:
        begin
          pcnt[page] = pcnt.exists(page) ? pcnt[page] + 1 : 1;
          if (pcnt[page] > 5) viol++;
          foreach (pbuf[i])
          begin
            k = page * 528 + col + i;
            mem[k] = (mem.exists(k) ? mem[k] : 8'hFF) & pbuf[i];
          end
          nprog++;
          start(PROG_NS, 1'b0);
        end
        8'hD0:
        begin
          for (k = page / 16 * 8448; k < page / 16 * 8448 + 8448; k++)
            mem.delete(k);
          for (k = page / 16 * 16; k < page / 16 * 16 + 16; k++)
            pcnt.delete(k);
          start(ERASE_NS, 1'b0);
        end
        default: ;
      endcase
    end
    else if (ale)
    begin
      a[8 * (na + (cmd == 8'h60 ? 1 : 0)) +: 8] = io;
      na++;
      col = a[7:0];
      page = a[23:8];
      if (cmd == 8'h00 && na == 3) start(FETCH_NS, 1'b1);
    end
    else if (cmd == 8'h80) pbuf.push_back(io);
  end

  // Output byte and column step on read strobe fall; host waits checked
  always @(negedge output_strobe_n) if (!ce_n)
  begin
    if (busy || $time - t_rdy < 20) viol++;
    if ($time - t_ale < (cmd == 8'h90 ? 100 : 50)) viol++;
    if (cmd == 8'h90 && $time - t_ce < 100) viol++;
    k = page * 528 + col;
    dq = cmd == 8'h90 ? (col == 0 ? ID0 : ID1)
                      : (mem.exists(k) ? mem[k] : 8'hFF);
    col++;
    dq_oe = 1'b1;
  end

  // Short output hold; next page fetched only if select stays low
  always @(posedge output_strobe_n)
  begin
    #10 dq_oe = 1'b0;
    if (cmd == 8'h00 && col == 528)
    begin
      #20 if (!ce_n)
      begin
        page++;
        col = 0;
        start(FETCH_NS, 1'b1);
      end
    end
  end
endmodule : nfc_dev_model

/* sim/tb_nfc_host.sv */
// Self-checking bench: host sequencer against the device model.
// Assumes nfc_dev_model in sim/ and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb_nfc_host;
  localparam int         TMO = 2000;
  localparam logic [7:0] ID0 = 8'h5A; // Arbitrary identity value
  localparam logic [7:0] ID1 = 8'hC3; // Arbitrary identity value
  logic sys_clk, nrst, clk_en, req_valid, wr_valid, rd_ready, slow, hang;
  logic req_ready, wr_ready, rd_valid, done, timeout_err, prog_limit_err;
  logic io_oe, ce_n, cle, ale, we_n, output_strobe_n, dq_oe, ready_busy_n;
  logic [7:0] wr_data, rd_data, io_out, dq, io_in, e8;
  nfc_pkg::nfc_req_s req;
  int   num_errors, samples_checked, cycles, seed, viol, nprog, n0;
  logic te, pe;
  logic [7:0] tmem [int];
  logic [7:0] wq [$];
  logic [7:0] expq [$];

  // Shared data pins: host, device, else last value inverted
  assign io_in = io_oe ? io_out : (dq_oe ? dq : ~dq);

  nfc_host #(.TIMEOUT_CYCLES(TMO), .FIFO_DEPTH(8)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .done(done), .timeout_err(timeout_err),
    .prog_limit_err(prog_limit_err), .ready_busy_n(ready_busy_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n));

  nfc_dev_model #(.ID0(ID0), .ID1(ID1)) dev (
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .output_strobe_n(output_strobe_n), .io(io_in), .slow(slow),
    .hang(hang), .ready_busy_n(ready_busy_n), .dq(dq), .dq_oe(dq_oe),
    .viol(viol), .nprog(nprog));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Write stream, random back-pressure and clock enable at falling edge
  always @(negedge sys_clk)
  begin
    wr_valid <= wq.size() != 0;
    wr_data  <= wq.size() != 0 ? wq[0] : 8'h00;
    rd_ready <= ($random(seed) % 4) != 0;
    clk_en   <= ($random(seed) % 8) != 0;
  end

  // Accept writes, compare read bytes, bound the run
  always @(posedge sys_clk)
  begin
    if (wr_valid && wr_ready === 1'b1 && clk_en) void'(wq.pop_front());
    if (rd_valid === 1'b1 && rd_ready && clk_en)
    begin
      e8 = expq.size() != 0 ? expq.pop_front() : 8'hXX;
      `CHK("rd_data", e8, rd_data)
    end
    cycles++;
    if (cycles == 90000)
    begin
      num_errors++;
      final_report();
    end
  end

  function automatic logic [7:0] tget(input int k);
    return tmem.exists(k) ? tmem[k] : 8'hFF;
  endfunction : tget

  // One request, then a bounded wait for its completion pulse
  task automatic run_op(input int op, input logic [23:0] ad, input int n);
    int w;
    w = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && w < 100)
    begin
      @(negedge sys_clk);
      w++;
    end
    req_valid = 1'b1;
    req = '{nfc_pkg::nfc_op_e'(op), ad, 10'(n)};
    // Hold the request until an enabled edge takes it
    @(posedge sys_clk);
    while (clk_en !== 1'b1)
      @(posedge sys_clk);
    @(negedge sys_clk);
    req_valid = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 8000)
    begin
      @(posedge sys_clk);
      #1 w++;
    end
    `CHK("done", 1'b1, done)
    te = timeout_err;
    pe = prog_limit_err;
  endtask : run_op

  task automatic rd_op(input int op, input logic [23:0] ad, input int n);
    for (int i = 0; i < n; i++)
      expq.push_back(op == 3 ? (i == 0 ? ID0 : ID1)
                             : tget(ad[23:8] * 528 + ad[7:0] + i));
    run_op(op, ad, n);
  endtask : rd_op

  // Program keeps only bits that are zero in either value
  task automatic prog_op(input logic [23:0] ad, input int n, input bit ok);
    int k;
    for (int i = 0; i < n; i++)
    begin
      e8 = 8'($random(seed));
      k = ad[23:8] * 528 + ad[7:0] + i;
      if (ok) wq.push_back(e8);
      if (ok) tmem[k] = tget(k) & e8;
    end
    run_op(1, ad, n);
  endtask : prog_op

  task automatic erase_op(input logic [23:0] ad);
    int b;
    b = int'(ad[23:12]) * 8448;
    for (int k = b; k < b + 8448; k++) tmem.delete(k);
    run_op(2, ad, 0);
  endtask : erase_op

  task automatic final_report();
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Main sequence
  initial
  begin
    {num_errors, samples_checked, cycles, n0} = '0;
    seed = 95291;
    {nrst, req_valid, wr_valid, wr_data, rd_ready, slow, hang} = '0;
    clk_en = 1'b1;
    req = '0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) nrst = 1'b1;
    rd_op(3, 24'h000000, 2);
    erase_op(24'h000200);
    rd_op(0, 24'h000205, 6);
    for (int i = 0; i < 5; i++)
    begin
      slow = i[0];
      prog_op(24'h000200, 20, 1'b1);
      `CHK("prog_err", 1'b0, pe)
      rd_op(0, {16'h0002, 8'($random(seed) & 8'h0F)}, 8);
    end
    n0 = nprog;
    prog_op(24'h000200, 20, 1'b0);
    `CHK("prog_limit", 1'b1, pe)
    `CHK("prog_count", n0, nprog)
    erase_op(24'h000210);
    prog_op(24'h000200, 20, 1'b1);
    `CHK("prog_clear", 1'b0, pe)
    rd_op(0, 24'h000200, 20);
    hang = 1'b1;
    run_op(0, 24'h001000, 4);
    `CHK("timeout", 1'b1, te)
    hang = 1'b0;
    run_op(4, 24'h000000, 0);
    `CHK("timeout_clear", 1'b0, te)
    rd_op(0, 24'h000208, 4);
    repeat (50) @(posedge sys_clk);
    `CHK("rd_left", 0, expq.size())
    `CHK("dev_rules", 0, viol)
    final_report();
  end
endmodule : tb_nfc_host
